// ---- rtl/contact_monitor.sv ----
// contact monitor top: debounce, status, alert, direct paths, supervisor
// assumes asynchronous pins sync'd here; serial framing outside
module contact_monitor #(
  parameter int TICK_DIV = 100000,
  parameter int TW = 20
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] contact_inputs,
  input wire logic kick_input,
  input wire logic undervoltage_sense,
  input wire logic chip_select_n,
  input wire logic read_done,
  input wire logic cmd_load,
  input wire logic [7:0] alert_mask_bits,
  input wire logic pair_polarity_sel_a,
  input wire logic pair_polarity_sel_b,
  input wire logic direct_path_disable,
  input wire logic [2:0] scan_config_field,
  input wire logic overheat_event,
  input wire logic [TW-1:0] settle_ticks,
  input wire logic [TW-1:0] reset_pulse_ticks,
  output logic [15:0] status_word,
  output logic alert_n_o,
  output logic alert_n_oe,
  output logic regulator_wake_n,
  output logic reset_n_o,
  output logic reset_n_oe,
  output logic direct_output_0,
  output logic direct_output_0_oe,
  output logic direct_output_1,
  output logic direct_output_1_oe,
  output logic overheat_flag_n,
  output logic sense_enable_01,
  output logic [1:0] battery_ref_pairs,
  output logic fixed_hysteresis,
  output logic scan_active
);
  if (TICK_DIV < 2) begin : g_div_check
    $error("TICK_DIV must be at least 2");
  end
  if (TW < 8) begin : g_tw_check
    $error("TW too narrow for settle range");
  end

  contact_if link ();

  // misc pin syncs: three stages, accept when last two agree
  logic [2:0] ks_q, us_q, cs_q, ks_d, us_d, cs_d;
  logic kick_lvl_q, kick_lvl_d, uv_lvl_q, uv_lvl_d, cs_lvl_q, cs_lvl_d;
  logic cs_fall;

  always_comb begin
    ks_d = {ks_q[1:0], kick_input};
    us_d = {us_q[1:0], undervoltage_sense};
    cs_d = {cs_q[1:0], chip_select_n};
    kick_lvl_d = (ks_q[1] == ks_q[2]) ? ks_q[2] : kick_lvl_q;
    uv_lvl_d = (us_q[1] == us_q[2]) ? us_q[2] : uv_lvl_q;
    cs_lvl_d = (cs_q[1] == cs_q[2]) ? cs_q[2] : cs_lvl_q;
    cs_fall = cs_lvl_q && !cs_lvl_d;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ks_q <= '0;
      us_q <= '0;
      cs_q <= 3'h7;
      kick_lvl_q <= 1'b0;
      uv_lvl_q <= 1'b0;
      cs_lvl_q <= 1'b1;
    end else begin
      ks_q <= ks_d;
      us_q <= us_d;
      cs_q <= cs_d;
      kick_lvl_q <= kick_lvl_d;
      uv_lvl_q <= uv_lvl_d;
      cs_lvl_q <= cs_lvl_d;
    end
  end

  // slow timebase
  localparam int DW = $clog2(TICK_DIV);
  logic [DW-1:0] div_q, div_d;
  logic tick;
  always_comb begin
    tick = (div_q == DW'(TICK_DIV - 1));
    div_d = tick ? '0 : div_q + DW'(1);
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) div_q <= '0;
    else div_q <= div_d;
  end

  glitch_filter #(.WIDTH(8)) u_filter (
    .ref_clk(ref_clk),
    .reset(reset),
    .raw_in(contact_inputs),
    .link(link)
  );

  kick_watchdog #(.CW(TW)) u_watch (
    .ref_clk(ref_clk),
    .reset(reset),
    .kick_sync(kick_lvl_q),
    .tick(tick),
    .pulse_ticks(reset_pulse_ticks),
    .link(link)
  );

  // configuration, loaded on command strobe
  logic [7:0] mask_q, mask_d;
  logic pa_q, pa_d, pb_q, pb_d, dis_q, dis_d;
  logic [2:0] scfg_q, scfg_d;
  always_comb begin
    mask_d = mask_q;
    pa_d = pa_q;
    pb_d = pb_q;
    dis_d = dis_q;
    scfg_d = scfg_q;
    if (cmd_load) begin
      mask_d = alert_mask_bits;
      pa_d = pair_polarity_sel_a;
      pb_d = pair_polarity_sel_b;
      dis_d = direct_path_disable;
      scfg_d = scan_config_field;
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mask_q <= contact_pkg::MASK_RESET;
      pa_q <= 1'b0;
      pb_q <= 1'b0;
      dis_q <= 1'b0;
      scfg_q <= contact_pkg::SCAN_NORMAL;
    end else begin
      mask_q <= mask_d;
      pa_q <= pa_d;
      pb_q <= pb_d;
      dis_q <= dis_d;
      scfg_q <= scfg_d;
    end
  end

  // closed contact level: ground pairs closed when low
  logic [7:0] closed;
  logic direct_mode, scan_cfg;
  always_comb begin
    scan_cfg = (scfg_q != contact_pkg::SCAN_NORMAL) &&
      (scfg_q != contact_pkg::SCAN_FIXED_THRESHOLD_BAND_PIN);
    direct_mode = !dis_q && !scan_cfg;
    closed[3:0] = ~link.filtered[3:0];
    closed[5:4] = pa_q ? link.filtered[5:4] : ~link.filtered[5:4];
    closed[7:6] = pb_q ? link.filtered[7:6] : ~link.filtered[7:6];
  end

  // shared debounce
  contact_pkg::mon_state_type st_q, st_d;
  logic [7:0] sw_q, sw_d, track;
  logic [TW-1:0] deb_q, deb_d;
  logic [7:0] start_q, start_d;
  logic int_q, int_d, in_scan_q, in_scan_d;
  logic ot_q, ot_d, event_set;
  logic [7:0] diff;

  always_comb begin
    track = {6'h3F, direct_mode ? 2'h0 : 2'h3};
    diff = (closed ^ sw_q) & track;
    st_d = st_q;
    sw_d = sw_q;
    deb_d = deb_q;
    start_d = start_q;
    event_set = 1'b0;
    in_scan_d = scan_cfg;
    case (st_q)
      contact_pkg::mon_idle_type: begin
        if (diff != 8'h00) begin
          st_d = contact_pkg::mon_settle_type;
          start_d = closed;
          deb_d = '0;
          in_scan_d = 1'b0;
        end
      end
      contact_pkg::mon_settle_type: begin
        in_scan_d = 1'b0;
        if (diff == 8'h00) begin
          st_d = contact_pkg::mon_idle_type;
          in_scan_d = scan_cfg;
        end else if (((closed ^ start_q) & track) != 8'h00) begin
          start_d = closed;
          deb_d = '0;
        end else if (tick) begin
          deb_d = deb_q + TW'(1);
          if (deb_q + TW'(1) >= settle_ticks) begin
            sw_d = (sw_q & ~track) | (closed & track);
            event_set = ((diff & ~mask_q) != 8'h00);
            st_d = contact_pkg::mon_idle_type;
            in_scan_d = scan_cfg;
          end
        end
      end
      default: st_d = contact_pkg::mon_idle_type;
    endcase
    // set wins over select clear
    int_d = event_set | (int_q & !cs_fall);
    if (read_done && !event_set) int_d = 1'b0;
    ot_d = overheat_event | (ot_q & !cs_fall);
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_q <= contact_pkg::mon_idle_type;
      sw_q <= '0;
      deb_q <= '0;
      start_q <= '0;
      int_q <= 1'b0;
      in_scan_q <= 1'b0;
      ot_q <= 1'b0;
    end else begin
      st_q <= st_d;
      sw_q <= sw_d;
      deb_q <= deb_d;
      start_q <= start_d;
      int_q <= int_d;
      in_scan_q <= in_scan_d;
      ot_q <= ot_d;
    end
  end

  // registered outputs
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      status_word <= '0;
      alert_n_o <= 1'b0;
      alert_n_oe <= 1'b0;
      regulator_wake_n <= 1'b1;
      reset_n_o <= 1'b0;
      reset_n_oe <= 1'b1;
      direct_output_0 <= 1'b0;
      direct_output_0_oe <= 1'b0;
      direct_output_1 <= 1'b0;
      direct_output_1_oe <= 1'b0;
      overheat_flag_n <= 1'b1;
      sense_enable_01 <= 1'b0;
      battery_ref_pairs <= '0;
      fixed_hysteresis <= 1'b0;
      scan_active <= 1'b0;
    end else begin
      status_word <= {sw_d, 8'h00};
      alert_n_o <= 1'b0;
      // watchdog alert kept off the latch so its reset pulse drops it
      alert_n_oe <= int_d | link.alert_req;
      regulator_wake_n <= !(int_d | link.alert_req);
      reset_n_o <= 1'b0;
      reset_n_oe <= link.reset_req | uv_lvl_q;
      direct_output_0 <= link.filtered[0];
      direct_output_0_oe <= direct_mode && !in_scan_d;
      direct_output_1 <= link.filtered[1];
      direct_output_1_oe <= direct_mode && !in_scan_d;
      overheat_flag_n <= !ot_d;
      sense_enable_01 <= !direct_mode;
      battery_ref_pairs <= {pb_q, pa_q};
      fixed_hysteresis <= (scfg_q == contact_pkg::SCAN_FIXED_THRESHOLD_BAND_PIN);
      scan_active <= in_scan_d;
    end
  end

  sequence s_settle_start;
    st_q == contact_pkg::mon_idle_type && diff != 8'h00;
  endsequence
  a_alert_on_event: assert property (@(posedge ref_clk) disable iff (reset)
    event_set |=> alert_n_oe)
    else $error("debounced change did not assert alert");
  a_settle_entry: assert property (@(posedge ref_clk) disable iff (reset)
    s_settle_start |=> st_q == contact_pkg::mon_settle_type)
    else $error("change did not start settle");
  a_wake_follows: assert property (@(posedge ref_clk) disable iff (reset)
    regulator_wake_n == !alert_n_oe)
    else $error("wake line disagrees with alert");
  a_direct_quiet: assert property (@(posedge ref_clk) disable iff (reset)
    $past(direct_mode) |->
      $stable(sw_q[1:0]))
    else $error("direct input tracked in status");
  a_revert_keeps: assert property (@(posedge ref_clk) disable iff (reset)
    (st_q == contact_pkg::mon_settle_type && diff == 8'h00) |=>
      $stable(sw_q))
    else $error("revert changed status");
  a_uv_reset: assert property (@(posedge ref_clk) disable iff (reset)
    uv_lvl_q |=> reset_n_oe)
    else $error("undervoltage did not drive reset");
  a_threshold_band_pin_fixed: assert property (@(posedge ref_clk) disable iff (reset)
    scfg_q == contact_pkg::SCAN_FIXED_THRESHOLD_BAND_PIN |=>
      fixed_hysteresis)
    else $error("fixed hysteresis not selected");
  a_mask_blocks: assert property (@(posedge ref_clk) disable iff (reset)
    event_set |-> (diff & ~mask_q) != 8'h00)
    else $error("masked input raised alert");
endmodule // contact_monitor

// ---- rtl/contact_pkg.sv ----
// constants shared by the contact monitor block
// assumes a single 100 MHz clock and plain-port configuration
package contact_pkg;
  localparam int CLK_MHZ = 100;
  localparam int GLITCH_NS = 20000;
  localparam int GLITCH_CYCLES = (GLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int WD1_MULT = 4;
  localparam int WD2_MULT = 8;
  localparam logic [2:0] SCAN_FIXED_THRESHOLD_BAND_PIN = 3'h6;
  localparam logic [2:0] SCAN_NORMAL = 3'h0;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam int STATUS_LSB = 8;
  localparam int SETTLE_MIN_TICKS = 5;
  localparam int SETTLE_MAX_TICKS = 100;
  typedef enum logic [1:0] {
    mon_idle_type = 2'h0,
    mon_settle_type = 2'h1
  } mon_state_type;
endpackage

// ---- rtl/contact_if.sv ----
// links between the monitor top and its filter and watchdog
// assumes all ends share ref_clk
interface contact_if;
  logic [7:0] filtered;
  logic alert_req;
  logic reset_req;
  modport filter (output filtered);
  modport watch (output alert_req, output reset_req);
  modport top (input filtered, input alert_req, input reset_req);
endinterface

// ---- rtl/glitch_filter.sv ----
// per-input synchroniser and short-pulse rejection
// assumes asynchronous contact inputs
module glitch_filter #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] raw_in,
  contact_if.filter link
);
  localparam int CW = $clog2(contact_pkg::GLITCH_CYCLES + 1);
  localparam logic [CW-1:0] GMAX = CW'(contact_pkg::GLITCH_CYCLES);
  logic [WIDTH-1:0] s1_q, s2_q, s3_q, s2_d, s3_d;
  logic [WIDTH-1:0] filt_q, filt_d;
  logic [CW-1:0] cnt_q [WIDTH], cnt_d [WIDTH];

  always_comb begin
    s2_d = s1_q;
    s3_d = s2_q;
    filt_d = filt_q;
    for (int i = 0; i < WIDTH; i++) begin
      cnt_d[i] = '0;
      if (s2_q[i] == s3_q[i] && s3_q[i] != filt_q[i]) begin
        cnt_d[i] = cnt_q[i] + CW'(1);
        if (cnt_q[i] >= GMAX - CW'(1)) begin
          filt_d[i] = s3_q[i];
          cnt_d[i] = '0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      // open ground contact idles high: no false change after reset
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      filt_q <= '1;
      for (int i = 0; i < WIDTH; i++) cnt_q[i] <= '0;
    end else begin
      s1_q <= raw_in;
      s2_q <= s2_d;
      s3_q <= s3_d;
      filt_q <= filt_d;
      for (int i = 0; i < WIDTH; i++) cnt_q[i] <= cnt_d[i];
    end
  end

  assign link.filtered = filt_q;

  a_glitch_hold: assert property (@(posedge ref_clk) disable iff (reset)
    (($past(s3_q) ^ filt_q) & ($past(filt_q) ^ filt_q)) == '0)
    else $error("filtered level not taken from stable input");
endmodule // glitch_filter

// ---- rtl/kick_watchdog.sv ----
// watchdog with staged alert then reset pulse
// assumes a synchronised kick level and a tick strobe
module kick_watchdog #(
  parameter int CW = 20
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic kick_sync,
  input wire logic tick,
  input wire logic [CW-1:0] pulse_ticks,
  contact_if.watch link
);
  logic kick_q, kick_d;
  logic [CW+3:0] cnt_q, cnt_d;
  logic alert_q, alert_d, rst_q, rst_d;
  logic [CW-1:0] rcnt_q, rcnt_d;
  logic [CW+3:0] t1, t2;

  always_comb begin
    t1 = (CW+4)'(pulse_ticks) * (CW+4)'(contact_pkg::WD1_MULT);
    t2 = (CW+4)'(pulse_ticks) * (CW+4)'(contact_pkg::WD2_MULT);
    kick_d = kick_sync;
    cnt_d = cnt_q;
    alert_d = alert_q;
    rst_d = rst_q;
    rcnt_d = rcnt_q;
    if (rst_q) begin
      if (tick) rcnt_d = rcnt_q + CW'(1);
      if (tick && rcnt_q >= pulse_ticks - CW'(1)) begin
        rst_d = 1'b0;
        rcnt_d = '0;
      end
    end else if (kick_sync != kick_q) begin
      cnt_d = '0;
      alert_d = 1'b0;
    end else if (tick) begin
      cnt_d = cnt_q + (CW+4)'(1);
      if (cnt_q + (CW+4)'(1) >= t1) alert_d = 1'b1;
      if (cnt_q + (CW+4)'(1) >= t2) begin
        rst_d = 1'b1;
        alert_d = 1'b0;
        cnt_d = '0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      kick_q <= 1'b0;
      cnt_q <= '0;
      alert_q <= 1'b0;
      rst_q <= 1'b0;
      rcnt_q <= '0;
    end else begin
      kick_q <= kick_d;
      cnt_q <= cnt_d;
      alert_q <= alert_d;
      rst_q <= rst_d;
      rcnt_q <= rcnt_d;
    end
  end

  assign link.alert_req = alert_q;
  assign link.reset_req = rst_q;

  a_kick_restart: assert property (@(posedge ref_clk) disable iff (reset)
    (!rst_q && kick_sync != kick_q) |=> cnt_q == '0)
    else $error("kick edge did not restart watchdog");
  a_reset_clears: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(rst_q) |-> !alert_q)
    else $error("alert still held at reset pulse");
endmodule // kick_watchdog

// ---- sim/host_model.sv ----
// host controller model: kicks the watchdog, reads over select
// assumes the monitor and this model share ref_clk
module host_model #(
  parameter int KICK_GAP = 100,
  parameter bit WAKE_USED = 1'h1
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic kick_en,
  input wire logic read_req,
  input wire logic regulator_wake_n,
  output logic kick_input,
  output logic chip_select_n,
  output logic read_done,
  output logic regulator_hold,
  output logic regulator_on
);
  timeunit 1ns;
  timeprecision 1ps;
  int gap_q;
  int bits_q;
  assign regulator_on = !regulator_wake_n || regulator_hold;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      gap_q <= 0;
      bits_q <= 0;
      kick_input <= 1'h0;
      chip_select_n <= 1'h1;
      read_done <= 1'h0;
      regulator_hold <= 1'h0;
    end else begin
      gap_q <= (kick_en && gap_q < KICK_GAP - 1) ? gap_q + 1 : 0;
      if (kick_en && gap_q == KICK_GAP - 1) kick_input <= !kick_input;
      read_done <= 1'h0;
      if (read_req && chip_select_n) begin
        chip_select_n <= 1'h0;
        bits_q <= 16;
      end else if (!chip_select_n) begin
        bits_q <= bits_q - 1;
        if (bits_q == 1) begin
          chip_select_n <= 1'h1;
          read_done <= 1'h1;
        end
      end
      if (!WAKE_USED) regulator_hold <= 1'h0;
      else if (!regulator_wake_n) regulator_hold <= 1'h1;
      else if (read_done) regulator_hold <= 1'h0;
    end
  end
endmodule // host_model

// ---- sim/switch_monitor_debounce_supervisor_tb_top.sv ----
// self-checking bench for the contact monitor top
// assumes the host model drives select, read and kick lines
module switch_monitor_debounce_supervisor_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int sel; logic [15:0] exp;} note_type;
  logic ref_clk, reset, kick_input, undervoltage_sense, chip_select_n;
  logic read_done, cmd_load, pair_polarity_sel_a, pair_polarity_sel_b;
  logic direct_path_disable, overheat_event, kick_en, read_req;
  logic [7:0] contact_inputs, alert_mask_bits, mask;
  logic [2:0] scan_config_field;
  logic [19:0] settle_ticks, reset_pulse_ticks;
  logic [15:0] status_word, st;
  logic alert_n_o, alert_n_oe, regulator_wake_n, reset_n_o, reset_n_oe;
  logic direct_output_0, direct_output_0_oe, direct_output_1;
  logic direct_output_1_oe, overheat_flag_n, sense_enable_01;
  logic fixed_hysteresis, scan_active;
  logic [1:0] battery_ref_pairs;
  logic [14:0] flags;
  note_type q[$];
  note_type e;
  int err_total, checks, t;
  string names[15] = '{"status_word", "alert_n_oe", "regulator_wake_n",
    "reset_n_oe", "direct_output_0_oe", "scan_active", "fixed_hysteresis",
    "overheat_flag_n", "direct_output_0", "battery_ref_pairs",
    "sense_enable_01", "direct_output_1", "direct_output_1_oe", "alert_n_o",
    "reset_n_o"};

  contact_monitor #(.TICK_DIV(4), .TW(20)) contact_monitor_i (
    .ref_clk, .reset, .contact_inputs, .kick_input, .undervoltage_sense,
    .chip_select_n, .read_done, .cmd_load, .alert_mask_bits,
    .pair_polarity_sel_a, .pair_polarity_sel_b, .direct_path_disable,
    .scan_config_field, .overheat_event, .settle_ticks, .reset_pulse_ticks,
    .status_word, .alert_n_o, .alert_n_oe, .regulator_wake_n, .reset_n_o,
    .reset_n_oe, .direct_output_0, .direct_output_0_oe, .direct_output_1,
    .direct_output_1_oe, .overheat_flag_n, .sense_enable_01,
    .battery_ref_pairs, .fixed_hysteresis, .scan_active);
  host_model host_model_i (.ref_clk, .reset, .kick_en, .read_req,
    .regulator_wake_n, .kick_input, .chip_select_n, .read_done,
    .regulator_hold(), .regulator_on());

  assign flags = {reset_n_o, alert_n_o, direct_output_1_oe, direct_output_1,
    sense_enable_01, 1'h0, direct_output_0, overheat_flag_n,
    fixed_hysteresis, scan_active, direct_output_0_oe, reset_n_oe,
    regulator_wake_n, alert_n_oe, 1'h0};

  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic cmp_word(input int sel, input logic [15:0] exp);
    logic [15:0] got;
    got = (sel == 0) ? status_word : {14'h0000, battery_ref_pairs};
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", names[sel], exp, got);
    end
  endtask

  task automatic cmp_flag(input int sel, input logic exp);
    checks++;
    if (flags[sel] !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %b seen %b", names[sel], exp,
        flags[sel]);
    end
  endtask

  // oldest note first, once the outputs have settled
  always @(negedge ref_clk) begin
    while (q.size() > 0) begin
      e = q.pop_front();
      if (e.sel == 0 || e.sel == 9) cmp_word(e.sel, e.exp);
      else cmp_flag(e.sel, e.exp[0]);
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic note(input int sel, input logic [15:0] exp);
    q.push_back('{sel, exp});
  endtask

  task automatic wait_for(input int sel, input logic v, input int max);
    int n;
    n = 0;
    while (flags[sel] !== v && n < max) begin
      step(1);
      n++;
    end
    note(sel, {15'h0000, v});
  endtask

  task automatic read();
    read_req = 1'h1;
    step(1);
    read_req = 1'h0;
    step(30);
  endtask

  task automatic load(input logic [2:0] sc, input logic a, input logic dd);
    alert_mask_bits = mask;
    pair_polarity_sel_a = a;
    direct_path_disable = dd;
    scan_config_field = sc;
    cmd_load = 1'h1;
    step(1);
    cmd_load = 1'h0;
    step(3);
  endtask

  initial begin
    #800000;
    err_total++;
    summarize();
  end

  initial begin
    void'($urandom(74));
    {reset, kick_en, read_req, cmd_load} = 4'hC;
    {undervoltage_sense, overheat_event, pair_polarity_sel_a} = 3'h0;
    {pair_polarity_sel_b, direct_path_disable} = 2'h0;
    contact_inputs = 8'hFF;
    mask = 8'h00;
    alert_mask_bits = 8'h00;
    scan_config_field = 3'h0;
    settle_ticks = 20'h002BC;
    reset_pulse_ticks = 20'h00032;
    st = 16'h0000;
    step(2);
    reset = 1'h0;
    step(10);
    note(5, 0);
    note(9, 0);
    note(4, 1);
    note(10, 0);
    note(8, 1);
    note(11, 1);
    note(12, 1);
    note(13, 0);
    note(14, 0);
    note(3, 0);
    note(2, 1);
    contact_inputs[0] = 1'h0;
    step(2010);
    note(8, 0);
    // unmasked ground contact closes
    t = 2 + $urandom % 2;
    contact_inputs[t] = 1'h0;
    step(4000);
    note(1, 0);
    note(0, st);
    wait_for(1, 1, 3000);
    st[8 + t] = 1'h1;
    note(0, st);
    note(2, 0);
    read();
    note(1, 0);
    note(2, 1);
    // short glitch, then a change that reverts mid settle
    contact_inputs[5] = 1'h0;
    step(1000);
    contact_inputs[5] = 1'h1;
    step(6000);
    note(0, st);
    note(1, 0);
    contact_inputs[5] = 1'h0;
    step(2500);
    contact_inputs[5] = 1'h1;
    step(6000);
    note(0, st);
    note(1, 0);
    overheat_event = 1'h1;
    step(1);
    overheat_event = 1'h0;
    step(5);
    note(7, 0);
    read();
    note(7, 1);
    // direct path off, inputs 0 and 6 masked
    mask = (8'($urandom) & 8'h3E) | 8'h41;
    load(3'h0, 1'h0, 1'h1);
    note(4, 0);
    note(10, 1);
    note(12, 0);
    step(6000);
    st[8] = 1'h1;
    note(0, st);
    note(1, 0);
    contact_inputs[6] = 1'h0;
    step(6000);
    st[14] = 1'h1;
    note(0, st);
    note(1, 0);
    // scan mode wake, then a scan wake that reverts
    load(3'h1, 1'h0, 1'h1);
    note(5, 1);
    contact_inputs[7] = 1'h0;
    wait_for(5, 0, 2100);
    wait_for(1, 1, 4000);
    st[15] = 1'h1;
    note(0, st);
    wait_for(5, 1, 10);
    read();
    contact_inputs[7] = 1'h1;
    wait_for(5, 0, 2100);
    step(500);
    contact_inputs[7] = 1'h0;
    wait_for(5, 1, 4000);
    note(1, 0);
    note(0, st);
    load(3'h6, 1'h0, 1'h1);
    note(6, 1);
    note(5, 0);
    // kicks stop: alert, then reset pulse
    kick_en = 1'h0;
    step(680);
    note(1, 0);
    wait_for(1, 1, 150);
    step(700);
    note(3, 0);
    wait_for(3, 1, 120);
    note(1, 0);
    step(190);
    note(3, 1);
    wait_for(3, 0, 30);
    kick_en = 1'h1;
    step(20);
    undervoltage_sense = 1'h1;
    step(8);
    note(3, 1);
    undervoltage_sense = 1'h0;
    step(250);
    // inputs 4 and 5 flip to battery reference
    load(3'h6, 1'h1, 1'h1);
    note(9, 16'h0001);
    step(6000);
    st[13:12] = 2'h3;
    note(0, st);
    note(1, {15'h0000, mask[5:4] != 2'h3});
    step(3);
    summarize();
  end
endmodule // switch_monitor_debounce_supervisor_tb_top
